// File: shared/mcs_pkg.sv
//==========================================================
// Purpose: constants and types of the message crc segmenter
// Assumes: octet-wide streams, one clock
// Notes:   lengths in octets
//==========================================================
package mcs_pkg;

  // unit layout
  localparam logic [15:0] MCS_CHDR_LEN = 16'h0004;
  localparam logic [15:0] MCS_CVP_LEN = 16'h0014;
  localparam logic [15:0] MCS_CRC_LEN = 16'h0004;
  localparam logic [15:0] MCS_TRL_LEN = 16'h0004;
  localparam logic [15:0] MCS_OFS_PIPL = 16'h0010;
  localparam logic [15:0] MCS_OFS_QCH = 16'h0011;
  localparam logic [15:0] MCS_OFS_BRG_HI = 16'h0012;
  localparam logic [15:0] MCS_OFS_BRG_LO = 16'h0013;
  localparam logic [15:0] MCS_RX_OFS_BAS_HI = 16'h0002;
  localparam logic [15:0] MCS_RX_OFS_BAS_LO = 16'h0003;
  localparam logic [15:0] MCS_RX_OFS_PIPL = 16'h0014;
  localparam logic [15:0] MCS_RX_OFS_QCH = 16'h0015;
  localparam logic [15:0] MCS_RX_OFS_BRG_HI = 16'h0016;
  localparam logic [15:0] MCS_RX_OFS_BRG_LO = 16'h0017;
  localparam logic [15:0] MCS_RX_OFS_EXT = 16'h0018;
  localparam logic [5:0] MCS_PID_LLC = 6'h01;
  localparam logic [15:0] MCS_MAX_USER_FIELD_A = 16'h23E4;
  localparam logic [7:0] MCS_RESERVED_OCTET = 8'h00;

  // segment layout
  localparam logic [5:0] MCS_SU_LEN = 6'h2C;
  localparam logic [5:0] MCS_POS_SU_FIRST = 6'h02;
  localparam logic [5:0] MCS_POS_SU_LAST = 6'h2D;
  localparam logic [5:0] MCS_POS_TRL_HI = 6'h2E;
  localparam logic [5:0] MCS_POS_TRL_LO = 6'h2F;

  // check sequences
  localparam logic [31:0] MCS_CRC32_POLY = 32'h04C11DB7;
  localparam logic [31:0] MCS_CRC32_PRESET = 32'hFFFFFFFF;
  localparam logic [31:0] MCS_CRC32_RESIDUE = 32'hC704DD7B;
  localparam logic [9:0] MCS_CRC10_POLY = 10'h233;
  localparam logic [9:0] MCS_CRC10_PRESET = 10'h000;
  localparam logic [9:0] MCS_SGL_MID = 10'h000;

  typedef enum logic [1:0] {
    MCS_MIDDLE_SEGMENT = 2'b00,
    MCS_LAST_SEGMENT = 2'b01,
    MCS_FIRST_SEGMENT = 2'b10,
    MCS_SINGLE_SEGMENT = 2'b11
  } mcs_kind_type;

  typedef enum logic [2:0] {
    MCS_U_CHDR = 3'b000,
    MCS_U_BODY = 3'b001,
    MCS_U_PAD = 3'b010,
    MCS_U_CRC = 3'b011,
    MCS_U_TRL = 3'b100,
    MCS_U_DONE = 3'b101
  } mcs_phase_type;

endpackage

// File: shared/mcs_crc_if.sv
//==========================================================
// Purpose: link between a crc32 user and its engine
// Assumes: engine clocked by the user's clock
// Notes:   init wins over en
//==========================================================
`timescale 1ns/100ps
interface mcs_crc_if;
  logic init;
  logic en;
  logic [7:0] data;
  logic [31:0] crc;
  modport user (output init, output en, output data, input crc);
  modport engine (input init, input en, input data, output crc);
endinterface

// File: src/mcs_crc32.sv
//==========================================================
// Purpose: octet-serial 32-bit crc, msb first
// Assumes: preset on init
// Notes:   remainder exposed raw
//==========================================================
`timescale 1ns/100ps
module mcs_crc32 import mcs_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // crc port
  mcs_crc_if.engine crc_port
);

  function automatic logic [31:0] crc32_byte(logic [31:0] c,
                                             logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0} ^ (fb ? MCS_CRC32_POLY : 32'h00000000);
    end
    return r;
  endfunction

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      crc_port.crc <= MCS_CRC32_PRESET;
    end else if (crc_port.init) begin
      crc_port.crc <= MCS_CRC32_PRESET;
    end else if (crc_port.en) begin
      crc_port.crc <= crc32_byte(crc_port.crc, crc_port.data);
    end
  end

endmodule // mcs_crc32

// File: src/mcs_segmenter.sv
//==========================================================
// Purpose: builds message units, cuts them into segments,
//          and parses received message units
// Assumes: user gives lengths up front, streams protocol header,
//          extension and payload; rx unit arrives reassembled
// Notes:   segments leave as 48-octet streams
// Notes on behaviour
// - receiver skips extension when length nonzero
// - receiver accepts payloads up to 9188 octets
// - transmitter adds zero pad to four-octet multiple
// - crc32 covers protocol header to pad, bridge zeroed
// - crc32 uses the standard degree-32 generator
// - preset ones, send complement msb first
// - receiver residue check against fixed constant
// - receiver accounts crc octets when bit set
// - trailer: reserved, tag, two-octet length
// - reserved trailer octet sent as zero
// - trailer tag equals header tag
// - trailer length equals header allocation size
// - unit cut into 44-octet segmentation units
// - all segments share priority and bus
// - segment: header, unit slice, trailer
// - header: kind, sequence, identifier
// - kind codes middle 00 last 01 first 10 single 11
// - sequence starts at given count, wraps 16
// - same identifier per unit, single uses zero
// - payload length 44, else actual count
// - 10-bit check preset zero over segment
//==========================================================
`timescale 1ns/100ps
module mcs_segmenter import mcs_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // transmit command
  input wire logic tx_start,
  input wire logic [13:0] tx_user_field_a_len,
  input wire logic [2:0] tx_hdr_ext_len,
  input wire logic tx_crc_en,
  input wire logic [7:0] tx_begin_end_tag,
  input wire logic [9:0] tx_mid,
  input wire logic [3:0] tx_seq,
  input wire logic [2:0] tx_prio,
  input wire logic [1:0] tx_bus,
  output logic tx_idle,
  // transmit octet stream
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  // segment output
  output logic [7:0] seg_data,
  output logic seg_valid,
  output logic seg_sos,
  input wire logic seg_ready,
  output logic [2:0] seg_prio,
  output logic [1:0] seg_bus,
  // receive unit stream
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_check_en,
  output logic [7:0] rx_user_field_a_data,
  output logic rx_user_field_a_valid,
  output logic rx_llc,
  output logic rx_crc_present,
  output logic rx_done,
  output logic rx_crc_err
);

  function automatic logic [9:0] crc10_upd(logic [9:0] c,
                                           logic [7:0] d,
                                           int n);
    logic [9:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      if (i >= 8 - n) begin
        fb = r[9] ^ d[i];
        r = {r[8:0], 1'b0} ^ (fb ? MCS_CRC10_POLY : 10'h000);
      end
    end
    return r;
  endfunction

  //========================================================
  // transmit unit source
  mcs_crc_if tx_crc ();
  mcs_crc32 u_tx_crc (.mclk(mclk), .rst(rst), .crc_port(tx_crc));

  mcs_phase_type phase_q;
  logic [15:0] u_cnt_q;
  logic [15:0] body_len_q;
  logic [15:0] len_q;
  logic [1:0] pd_q;
  logic [2:0] xw_q;
  logic crc_en_q;
  logic [7:0] tag_q;
  logic [9:0] mid_q;
  logic [1:0] pd_d;
  logic [15:0] len_d;
  logic busy_q;
  logic ub_avail;
  logic [7:0] ub_data;
  logic ub_take;
  logic ph_end;
  mcs_phase_type ph_next;
  logic [7:0] crc_byte;
  logic accept;

  assign accept = tx_start && !busy_q;
  assign tx_idle = !busy_q;
  assign pd_d = 2'(2'b00 - tx_user_field_a_len[1:0]);
  assign len_d = 16'(MCS_CVP_LEN + {11'h000, tx_hdr_ext_len, 2'b00}
    + {2'b00, tx_user_field_a_len} + {14'h0000, pd_d}
    + (tx_crc_en ? MCS_CRC_LEN : 16'h0000));

  always_comb begin
    case (u_cnt_q[1:0])
      2'b00: crc_byte = ~tx_crc.crc[31:24];
      2'b01: crc_byte = ~tx_crc.crc[23:16];
      2'b10: crc_byte = ~tx_crc.crc[15:8];
      default: crc_byte = ~tx_crc.crc[7:0];
    endcase
  end

  always_comb begin
    ub_avail = 1'b1;
    ub_data = 8'h00;
    ph_end = 1'b0;
    case (phase_q)
      MCS_U_CHDR: begin
        ph_end = (u_cnt_q == MCS_CHDR_LEN - 16'h0001);
        case (u_cnt_q[1:0])
          2'b00: ub_data = MCS_RESERVED_OCTET;
          2'b01: ub_data = tag_q;
          2'b10: ub_data = len_q[15:8];
          default: ub_data = len_q[7:0];
        endcase
      end
      MCS_U_BODY: begin
        ub_avail = tx_valid;
        ph_end = (u_cnt_q == body_len_q - 16'h0001);
        if (u_cnt_q == MCS_OFS_PIPL) begin
          ub_data = {tx_data[7:2], pd_q};
        end else if (u_cnt_q == MCS_OFS_QCH) begin
          ub_data = {tx_data[7:4], crc_en_q, xw_q};
        end else begin
          ub_data = tx_data;
        end
      end
      MCS_U_PAD: begin
        ph_end = (u_cnt_q[1:0] == pd_q - 2'b01);
        ub_data = 8'h00;
      end
      MCS_U_CRC: begin
        ph_end = (u_cnt_q == MCS_CRC_LEN - 16'h0001);
        ub_data = crc_byte;
      end
      MCS_U_TRL: begin
        ph_end = (u_cnt_q == MCS_TRL_LEN - 16'h0001);
        case (u_cnt_q[1:0])
          2'b00: ub_data = MCS_RESERVED_OCTET;
          2'b01: ub_data = tag_q;
          2'b10: ub_data = len_q[15:8];
          default: ub_data = len_q[7:0];
        endcase
      end
      default: ub_avail = 1'b0;
    endcase
  end

  always_comb begin
    case (phase_q)
      MCS_U_CHDR: ph_next = MCS_U_BODY;
      MCS_U_BODY: ph_next = (pd_q != 2'b00) ? MCS_U_PAD :
        (crc_en_q ? MCS_U_CRC : MCS_U_TRL);
      MCS_U_PAD: ph_next = crc_en_q ? MCS_U_CRC : MCS_U_TRL;
      MCS_U_CRC: ph_next = MCS_U_TRL;
      default: ph_next = MCS_U_DONE;
    endcase
  end

  // crc32 over protocol header, extension, payload and pad
  assign tx_crc.init = accept;
  assign tx_crc.en = ub_take
    && (phase_q == MCS_U_BODY || phase_q == MCS_U_PAD);
  assign tx_crc.data = (phase_q == MCS_U_BODY
    && (u_cnt_q == MCS_OFS_BRG_HI || u_cnt_q == MCS_OFS_BRG_LO))
    ? 8'h00 : ub_data;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phase_q <= MCS_U_DONE;
      u_cnt_q <= 16'h0000;
    end else if (accept) begin
      phase_q <= MCS_U_CHDR;
      u_cnt_q <= 16'h0000;
    end else if (ub_take) begin
      if (ph_end) begin
        phase_q <= ph_next;
        u_cnt_q <= 16'h0000;
      end else begin
        u_cnt_q <= 16'(u_cnt_q + 16'h0001);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      body_len_q <= 16'h0000;
      len_q <= 16'h0000;
      pd_q <= 2'b00;
      xw_q <= 3'b000;
      crc_en_q <= 1'b0;
      tag_q <= 8'h00;
      mid_q <= 10'h000;
      seg_prio <= 3'b000;
      seg_bus <= 2'b00;
    end else if (accept) begin
      body_len_q <= 16'(MCS_CVP_LEN + {11'h000, tx_hdr_ext_len, 2'b00}
        + {2'b00, tx_user_field_a_len});
      len_q <= len_d;
      pd_q <= pd_d;
      xw_q <= tx_hdr_ext_len;
      crc_en_q <= tx_crc_en;
      tag_q <= tx_begin_end_tag;
      mid_q <= tx_mid;
      seg_prio <= tx_prio;
      seg_bus <= tx_bus;
    end
  end

  //========================================================
  // segmenter
  logic [5:0] pos_q;
  logic [15:0] left_q;
  logic [5:0] seg_len_q;
  logic [5:0] su_cnt_q;
  logic first_q;
  logic [3:0] seq_q;
  logic [9:0] c10_q;
  mcs_kind_type kind;
  mcs_kind_type kind_q;
  logic in_su;
  logic su_has;
  logic out_free;
  logic step;
  logic [7:0] octet;
  logic [9:0] c10_fin;
  logic [9:0] seg_mid;

  always_comb begin
    if (left_q <= {10'h000, MCS_SU_LEN}) begin
      kind = first_q ? MCS_SINGLE_SEGMENT : MCS_LAST_SEGMENT;
    end else begin
      kind = first_q ? MCS_FIRST_SEGMENT : MCS_MIDDLE_SEGMENT;
    end
  end

  assign seg_mid = (((pos_q == 6'h00) ? kind : kind_q)
    == MCS_SINGLE_SEGMENT) ? MCS_SGL_MID : mid_q;
  assign in_su = (pos_q >= MCS_POS_SU_FIRST)
    && (pos_q <= MCS_POS_SU_LAST);
  assign su_has = in_su && (su_cnt_q < seg_len_q);
  assign out_free = !seg_valid || seg_ready;
  assign step = busy_q && out_free && (!su_has || ub_avail);
  assign ub_take = step && su_has;
  assign tx_ready = (phase_q == MCS_U_BODY) && busy_q && out_free
    && su_has;
  assign c10_fin = crc10_upd(c10_q, {seg_len_q, 2'b00}, 6);

  always_comb begin
    if (pos_q == 6'h00) begin
      octet = {kind, seq_q, seg_mid[9:8]};
    end else if (pos_q == 6'h01) begin
      octet = seg_mid[7:0];
    end else if (in_su) begin
      octet = su_has ? ub_data : 8'h00;
    end else if (pos_q == MCS_POS_TRL_HI) begin
      octet = {seg_len_q, c10_fin[9:8]};
    end else begin
      octet = c10_q[7:0];
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_q <= 1'b0;
      pos_q <= 6'h00;
      left_q <= 16'h0000;
      seg_len_q <= 6'h00;
      su_cnt_q <= 6'h00;
      first_q <= 1'b0;
      seq_q <= 4'h0;
      kind_q <= MCS_MIDDLE_SEGMENT;
      c10_q <= MCS_CRC10_PRESET;
    end else if (accept) begin
      busy_q <= 1'b1;
      pos_q <= 6'h00;
      left_q <= 16'(len_d + MCS_CHDR_LEN + MCS_TRL_LEN);
      first_q <= 1'b1;
      seq_q <= tx_seq;
    end else if (step) begin
      if (pos_q == 6'h00) begin
        kind_q <= kind;
        seg_len_q <= (left_q <= {10'h000, MCS_SU_LEN})
          ? left_q[5:0] : MCS_SU_LEN;
        c10_q <= crc10_upd(MCS_CRC10_PRESET, octet, 8);
      end else if (pos_q < MCS_POS_TRL_HI) begin
        c10_q <= crc10_upd(c10_q, octet, 8);
      end else if (pos_q == MCS_POS_TRL_HI) begin
        c10_q <= c10_fin;
      end
      su_cnt_q <= in_su ? 6'(su_cnt_q + 6'h01) : 6'h00;
      if (ub_take) begin
        left_q <= 16'(left_q - 16'h0001);
      end
      if (pos_q == MCS_POS_TRL_LO) begin
        pos_q <= 6'h00;
        first_q <= 1'b0;
        seq_q <= 4'(seq_q + 4'h1);
        busy_q <= (left_q != 16'h0000);
      end else begin
        pos_q <= 6'(pos_q + 6'h01);
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      seg_data <= 8'h00;
      seg_valid <= 1'b0;
      seg_sos <= 1'b0;
    end else if (step) begin
      seg_data <= octet;
      seg_valid <= 1'b1;
      seg_sos <= (pos_q == 6'h00);
    end else if (seg_ready) begin
      seg_valid <= 1'b0;
      seg_sos <= 1'b0;
    end
  end

  //========================================================
  // receive parser
  mcs_crc_if rx_crc ();
  mcs_crc32 u_rx_crc (.mclk(mclk), .rst(rst), .crc_port(rx_crc));

  logic [15:0] rx_cnt_q;
  logic [15:0] rx_len_q;
  logic [2:0] rx_xw_q;
  logic [1:0] rx_pd_q;
  logic [15:0] p;
  logic [15:0] ext_end;
  logic [15:0] user_field_a_end;
  logic [15:0] cov_end;
  logic in_body;

  assign p = rx_first ? 16'h0000 : rx_cnt_q;
  assign in_body = (p >= MCS_RX_OFS_EXT);
  assign ext_end = 16'(MCS_RX_OFS_EXT + {11'h000, rx_xw_q, 2'b00});
  assign cov_end = 16'(rx_len_q + MCS_CHDR_LEN);
  assign user_field_a_end = 16'(cov_end - {14'h0000, rx_pd_q}
    - (rx_crc_present ? MCS_CRC_LEN : 16'h0000));

  assign rx_crc.init = rx_valid && rx_first;
  assign rx_crc.en = rx_valid && (p >= MCS_CHDR_LEN) && (p < cov_end);
  assign rx_crc.data = (p == MCS_RX_OFS_BRG_HI || p == MCS_RX_OFS_BRG_LO)
    ? 8'h00 : rx_data;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_cnt_q <= 16'h0000;
      rx_len_q <= 16'h0000;
      rx_xw_q <= 3'b000;
      rx_pd_q <= 2'b00;
      rx_crc_present <= 1'b0;
      rx_llc <= 1'b0;
    end else if (rx_valid) begin
      rx_cnt_q <= 16'(p + 16'h0001);
      if (p == MCS_RX_OFS_BAS_HI) begin
        rx_len_q[15:8] <= rx_data;
      end
      if (p == MCS_RX_OFS_BAS_LO) begin
        rx_len_q[7:0] <= rx_data;
      end
      if (p == MCS_RX_OFS_PIPL) begin
        rx_pd_q <= rx_data[1:0];
        rx_llc <= (rx_data[7:2] == MCS_PID_LLC);
      end
      if (p == MCS_RX_OFS_QCH) begin
        rx_xw_q <= rx_data[2:0];
        rx_crc_present <= rx_data[3];
      end
    end
  end

  // 16-bit counters cover every payload up to the largest
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rx_user_field_a_data <= 8'h00;
      rx_user_field_a_valid <= 1'b0;
      rx_done <= 1'b0;
      rx_crc_err <= 1'b0;
    end else begin
      rx_user_field_a_valid <= rx_valid && in_body && (p >= ext_end)
        && (p < user_field_a_end);
      if (rx_valid) begin
        rx_user_field_a_data <= rx_data;
      end
      rx_done <= rx_valid && in_body
        && (p == 16'(cov_end + MCS_TRL_LEN - 16'h0001));
      if (rx_valid && in_body
          && (p == 16'(cov_end + MCS_TRL_LEN - 16'h0001))) begin
        rx_crc_err <= rx_check_en && rx_crc_present
          && (rx_crc.crc != MCS_CRC32_RESIDUE);
      end else if (rx_valid && rx_first) begin
        rx_crc_err <= 1'b0;
      end
    end
  end

endmodule // mcs_segmenter

// File: verif/mcs_segmenter_props.sv
//==========================================================
// Purpose: port checks of the segmenter
// Assumes: one clock, async high reset
// Notes:   bound to every segmenter
//==========================================================
`timescale 1ns/100ps
module mcs_segmenter_props (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // transmit side
  input wire logic tx_start,
  input wire logic [2:0] tx_prio,
  input wire logic [1:0] tx_bus,
  input wire logic tx_idle,
  input wire logic tx_ready,
  // segment side
  input wire logic [7:0] seg_data,
  input wire logic seg_valid,
  input wire logic seg_sos,
  input wire logic seg_ready,
  input wire logic [2:0] seg_prio,
  input wire logic [1:0] seg_bus,
  // receive side
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_crc_present,
  input wire logic rx_done,
  input wire logic rx_crc_err
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  //========================================
  // octet position in a segment
  logic [5:0] pos_q;
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pos_q <= 6'h00;
    end else if (seg_valid && seg_ready) begin
      pos_q <= (pos_q == 6'h2F) ? 6'h00 : 6'(pos_q + 6'h01);
    end
  end
  //========================================
  // checks
  a_start_busy: assert property (tx_start && tx_idle |=> !tx_idle)
    else $error("start did not make the transmitter busy");
  a_first_octet: assert property (tx_start && tx_idle && !seg_valid
    |=> ##1 seg_sos)
    else $error("segment did not open after start");
  a_stall_hold: assert property (seg_valid && !seg_ready |=>
    seg_valid && $stable(seg_data) && $stable(seg_sos))
    else $error("segment octet moved while stalled");
  a_stall_ready: assert property (seg_valid && !seg_ready |-> !tx_ready)
    else $error("stream accepted while segment stalled");
  a_prio_copy: assert property (tx_start && tx_idle |=>
    seg_prio == $past(tx_prio) && seg_bus == $past(tx_bus))
    else $error("priority or bus not copied at start");
  a_prio_hold: assert property (!tx_idle && !$past(tx_idle) |->
    $stable(seg_prio) && $stable(seg_bus))
    else $error("priority or bus changed within a unit");
  a_sos_place: assert property (seg_valid |-> seg_sos == (pos_q == 6'h00))
    else $error("segment start not every 48 octets");
  a_err_hold: assert property ($changed(rx_crc_err) |->
    rx_done || ($past(rx_first) && $past(rx_valid)))
    else $error("crc error flag changed outside unit end");
  a_err_cause: assert property (rx_done && rx_crc_err |-> rx_crc_present)
    else $error("crc error without crc present");
  c_single: cover property (seg_sos && seg_data[7:6] == 2'b11);
  c_stall: cover property (seg_valid && !seg_ready);
  c_err: cover property (rx_done && rx_crc_err);
endmodule // mcs_segmenter_props

bind mcs_segmenter mcs_segmenter_props i_props (
  .mclk(mclk), .rst(rst), .tx_start(tx_start), .tx_prio(tx_prio),
  .tx_bus(tx_bus), .tx_idle(tx_idle), .tx_ready(tx_ready),
  .seg_data(seg_data), .seg_valid(seg_valid), .seg_sos(seg_sos),
  .seg_ready(seg_ready), .seg_prio(seg_prio), .seg_bus(seg_bus),
  .rx_valid(rx_valid), .rx_first(rx_first),
  .rx_crc_present(rx_crc_present), .rx_done(rx_done),
  .rx_crc_err(rx_crc_err)
);

// File: verif/mcs_seg_sink.sv
//==========================================================
// Purpose: segment consumer model
// Assumes: one octet per edge while ready
// Notes:   stall_en drops ready one cycle in four
//==========================================================
`timescale 1ns/100ps
module mcs_seg_sink (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // segment stream
  input wire logic [7:0] seg_data,
  input wire logic seg_valid,
  output logic seg_ready,
  // control
  input wire logic stall_en
);
  logic [7:0] q[$];
  logic [1:0] ph = 2'h0;
  always @(negedge mclk) begin
    ph <= ph + 2'h1;
    seg_ready <= !rst && !(stall_en && ph == 2'h0);
  end
  always @(posedge mclk) begin
    if (seg_valid && seg_ready) q.push_back(seg_data);
  end
endmodule // mcs_seg_sink

// File: verif/mcs_segmenter_tb.sv
//==========================================================
// Purpose: self-checking bench of the segmenter
// Assumes: sink model on the segment side
// Notes:   inputs move on falling edges
//==========================================================
`timescale 1ns/100ps
module mcs_segmenter_tb import mcs_pkg::*;;
  logic mclk, rst, tx_start, tx_crc_en, tx_valid, rx_valid, rx_first;
  logic rx_check_en, stall_en, tx_idle, tx_ready, seg_valid, seg_sos;
  logic seg_ready, rx_user_field_a_valid, rx_llc, rx_crc_present, rx_done;
  logic rx_crc_err, done_err;
  logic [13:0] tx_user_field_a_len;
  logic [2:0] tx_hdr_ext_len, tx_prio, seg_prio;
  logic [7:0] tx_begin_end_tag, tx_data, seg_data, rx_data, rx_user_field_a_data;
  logic [9:0] tx_mid, c10v;
  logic [3:0] tx_seq;
  logic [1:0] tx_bus, seg_bus;
  logic [7:0] src[$], unit[$], seg[$], rxq[$];
  int err_total, comparisons, cyc, dones;

  mcs_segmenter i_dut (.mclk(mclk), .rst(rst), .tx_start(tx_start),
    .tx_user_field_a_len(tx_user_field_a_len), .tx_hdr_ext_len(tx_hdr_ext_len),
    .tx_crc_en(tx_crc_en), .tx_begin_end_tag(tx_begin_end_tag),
    .tx_mid(tx_mid), .tx_seq(tx_seq), .tx_prio(tx_prio), .tx_bus(tx_bus),
    .tx_idle(tx_idle), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .seg_data(seg_data), .seg_valid(seg_valid),
    .seg_sos(seg_sos), .seg_ready(seg_ready), .seg_prio(seg_prio),
    .seg_bus(seg_bus), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_first(rx_first), .rx_check_en(rx_check_en),
    .rx_user_field_a_data(rx_user_field_a_data), .rx_user_field_a_valid(rx_user_field_a_valid),
    .rx_llc(rx_llc), .rx_crc_present(rx_crc_present),
    .rx_done(rx_done), .rx_crc_err(rx_crc_err));
  mcs_seg_sink i_sink (.mclk(mclk), .rst(rst), .seg_data(seg_data),
    .seg_valid(seg_valid), .seg_ready(seg_ready), .stall_en(stall_en));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rx_user_field_a_valid) rxq.push_back(rx_user_field_a_data);
    if (rx_done) dones++;
    if (rx_done) done_err = rx_crc_err;
  end
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      final_report();
    end
  end
  //========================================
  // helpers
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask
  function automatic logic [31:0] c32(logic [31:0] c, logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? MCS_CRC32_POLY : 32'h0);
    end
    return c;
  endfunction
  function automatic logic [9:0] c10(logic [9:0] c, logic [7:0] d, int nb);
    for (int i = 7; i > 7 - nb; i--) begin
      c = {c[8:0], 1'b0} ^ ((c[9] ^ d[i]) ? MCS_CRC10_POLY : 10'h0);
    end
    return c;
  endfunction
  task automatic build(int user_field_a, int hx, bit crc, logic [7:0] tag);
    int pad, n;
    logic [15:0] len;
    logic [31:0] c;
    logic [7:0] b;
    pad = 3 - ((user_field_a + 3) % 4);
    n = 20 + 4 * hx + user_field_a;
    len = 16'(n + pad + 4 * crc);
    src = {};
    unit = {8'h00, tag, len[15:8], len[7:0]};
    c = MCS_CRC32_PRESET;
    for (int i = 0; i < n + pad; i++) begin
      b = (i < 20) ? 8'(i + 64) : 8'(i * 7 + 1);
      if (i == 16) b = 8'h07;
      if (i == 17) b = 8'h2F;
      if (i == 18 || i == 19) b = 8'hA5;
      if (i < n) src.push_back(b);
      else b = 8'h00;
      if (i == 16) b = {b[7:2], 2'(pad)};
      if (i == 17) b = {b[7:4], crc, 3'(hx)};
      unit.push_back(b);
      c = c32(c, (i == 18 || i == 19) ? 8'h00 : b);
    end
    c = ~c;
    if (crc) unit = {unit, c[31:24], c[23:16], c[15:8], c[7:0]};
    unit = {unit, 8'h00, tag, len[15:8], len[7:0]};
  endtask
  task automatic put(logic [7:0] o);
    seg.push_back(o);
    c10v = c10(c10v, o, 8);
  endtask
  task automatic cut(logic [9:0] mid, logic [3:0] seq);
    int n, pn, p;
    logic [15:0] h;
    n = (unit.size() + 43) / 44;
    seg = {};
    for (int s = 0; s < n; s++) begin
      h[15:14] = (s == 0) ? 2'b10 : (s == n - 1) ? 2'b01 : 2'b00;
      if (n == 1) h[15:14] = 2'b11;
      h[13:10] = seq + 4'(s);
      h[9:0] = (n == 1) ? MCS_SGL_MID : mid;
      pn = (s == n - 1) ? unit.size() - 44 * s : 44;
      c10v = MCS_CRC10_PRESET;
      put(h[15:8]);
      put(h[7:0]);
      for (int j = 0; j < 44; j++) begin
        p = 44 * s + j;
        put((p < unit.size()) ? unit[p] : 8'h00);
      end
      c10v = c10(c10v, {6'(pn), 2'b00}, 6);
      seg.push_back({6'(pn), c10v[9:8]});
      seg.push_back(c10v[7:0]);
    end
  endtask
  task automatic tx_run(int user_field_a, int hx, bit crc, logic [7:0] tag,
      logic [9:0] mid, logic [3:0] seq);
    int k;
    build(user_field_a, hx, crc, tag);
    cut(mid, seq);
    i_sink.q = {};
    @(negedge mclk);
    tx_user_field_a_len = 14'(user_field_a);
    tx_hdr_ext_len = 3'(hx);
    tx_crc_en = crc;
    tx_begin_end_tag = tag;
    tx_mid = mid;
    tx_seq = seq;
    tx_start = 1'b1;
    @(negedge mclk);
    tx_start = 1'b0;
    foreach (src[i]) begin
      tx_data = src[i];
      tx_valid = 1'b1;
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (tx_ready !== 1'b1 && k < 500);
      @(negedge mclk);
    end
    tx_valid = 1'b0;
    for (k = 0; k < 500 && (tx_idle !== 1'b1 || seg_valid !== 1'b0);
        k++) @(posedge mclk);
    @(negedge mclk);
    chk("segment octets", seg.size(), i_sink.q.size());
    foreach (seg[i]) chk("octet", seg[i], i_sink.q[i]);
  endtask
  task automatic rx_run(int user_field_a, int hx, bit crc, bit flip, logic err);
    int b;
    b = 24 + 4 * hx;
    if (flip) unit[b] = unit[b] ^ 8'h01;
    rxq = {};
    dones = 0;
    rx_check_en = err || !flip;
    foreach (unit[i]) begin
      @(negedge mclk);
      rx_data = unit[i];
      rx_first = (i == 0);
      rx_valid = 1'b1;
    end
    @(negedge mclk);
    rx_valid = 1'b0;
    rx_first = 1'b0;
    repeat (4) @(negedge mclk);
    chk("rx done", 1, dones);
    chk("rx payload size", user_field_a, rxq.size());
    foreach (rxq[i]) chk("rx payload", unit[b + i], rxq[i]);
    chk("rx llc", 1, rx_llc);
    chk("rx crc present", crc, rx_crc_present);
    chk("rx crc err", err, done_err);
  endtask
  //========================================
  // scenarios
  task automatic test_single();
    tx_prio = 3'h5;
    tx_bus = 2'h2;
    tx_run(5, 0, 0, 8'h3C, 10'h155, 4'hF);
    $display("test single segment done");
  endtask
  task automatic test_multi();
    stall_en = 1'b1;
    tx_prio = 3'h2;
    tx_bus = 2'h1;
    tx_run(90, 1, 1, 8'hC3, 10'h2AA, 4'hE);
    stall_en = 1'b0;
    $display("test three segments done");
  endtask
  task automatic test_rx();
    build(41, 1, 1, 8'h5A);
    rx_run(41, 1, 1, 0, 1'b0);
    build(41, 1, 1, 8'h5A);
    rx_run(41, 1, 1, 1, 1'b1);
    build(41, 1, 1, 8'h5A);
    rx_run(41, 1, 1, 1, 1'b0);
    build(9188, 0, 0, 8'h11);
    rx_run(9188, 0, 0, 0, 1'b0);
    $display("test receive done");
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    {tx_start, tx_crc_en, tx_valid, rx_valid, rx_first} = '0;
    {rx_check_en, stall_en, tx_user_field_a_len, tx_hdr_ext_len} = '0;
    {tx_begin_end_tag, tx_mid, tx_seq, tx_prio, tx_bus} = '0;
    {tx_data, rx_data} = '0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    rst = 1'b0;
    test_single();
    test_multi();
    test_rx();
    final_report();
  end
endmodule // mcs_segmenter_tb
